// file: rtl/xmem_pkg.sv
// constants, types and helpers shared by the external memory configuration block
package xmem_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] MCU_CTRL_OFS = 8'h00;
   localparam logic [7:0] XMEM_A_OFS   = 8'h01;
   localparam logic [7:0] XMEM_B_OFS   = 8'h02;

   localparam logic [7:0] MCU_CTRL_RST = 8'h00;
   localparam logic [7:0] XMEM_A_RST   = 8'h00;
   localparam logic [7:0] XMEM_B_RST   = 8'h00;

   // writable bits; all others read as zero
   localparam logic [7:0] MCU_CTRL_WMASK = 8'hC0;
   localparam logic [7:0] XMEM_A_WMASK   = 8'h7E;
   localparam logic [7:0] XMEM_B_WMASK   = 8'h87;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int EXT_EN_BIT    = 7;
   localparam int UP_WAIT_LO    = 6;
   localparam int SEC_LIMIT_LSB = 4;
   localparam int LO_WAIT_LSB   = 2;
   localparam int UP_WAIT_HI    = 1;
   localparam int KEEPER_BIT    = 7;
   localparam int HI_MASK_LSB   = 0;

   localparam int          SECTOR_SHIFT = 13;
   localparam logic [2:0]  MASK_ALL     = 3'h7;
   localparam logic [1:0]  WAIT_GAP     = 2'h3;
   localparam logic [7:0]  PINS_OFF     = 8'hFF;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic        write;
      logic [7:0]  wdata;
   } acc_req_type;

   typedef struct packed {
      logic [2:0] limit;
      logic [1:0] upWait;
      logic [1:0] loWait;
   } sector_cfg_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_STROBE,
      ST_GAP
   } acc_state_type;

   // extra strobe cycles for a wait-state select
   function automatic logic [1:0] strobeWaits(input logic [1:0] code);
      logic [1:0] w;
      w = 2'h0;
      if (code == 2'h1) begin
         w = 2'h1;
      end else if (code != 2'h0) begin
         w = 2'h2;
      end
      return w;
   endfunction

endpackage

// file: rtl/sector_select.sv
// picks the wait-state select of the sector an address falls in
`timescale 1ns/1ns
module sector_select (
   input  wire logic [15:0]                    addr,
   input  wire xmem_pkg::sector_cfg_type        cfg,
   output logic [1:0]                           waitCode
);

   logic [15:0] boundary;

   always_comb begin
      boundary = 16'(cfg.limit) << xmem_pkg::SECTOR_SHIFT;
      // limit zero means one sector, governed by the upper select
      if (cfg.limit == 3'h0) begin
         waitCode = cfg.upWait;
      end else if (addr >= boundary) begin
         waitCode = cfg.upWait;
      end else begin
         waitCode = cfg.loWait;
      end
   end

endmodule

// file: rtl/high_addr_mask.sv
// turns the high-address mask code into a per-pin release mask
`timescale 1ns/1ns
module high_addr_mask (
   input  wire logic [2:0] code,
   output logic [7:0]      released
);

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         // code n frees the top n pins; the all-ones code frees all eight
         assign released[i] = (code == xmem_pkg::MASK_ALL) ||
                              ((4'(i) + {1'b0, code}) >= 4'h8);
      end
   endgenerate

endmodule

// file: rtl/xmem_waitstate_config.sv
// external memory interface: sector wait-states, high-address mask, bus keeper
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module xmem_waitstate_config (
   input  wire logic                  mclk,
   input  wire logic                  srst,
   input  wire logic [7:0]            regAddr,
   input  wire logic [7:0]            regWdata,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   output logic [7:0]                 regRdata,
   input  wire logic                  accReq,
   input  wire xmem_pkg::acc_req_type accIn,
   output logic                       accBusy,
   output logic                       accDone,
   output logic [7:0]                 accRdata,
   input  wire logic [7:0]            adIn,
   output logic [7:0]                 adOut,
   output logic                       adOeN,
   output logic [7:0]                 hiAddrOut,
   output logic [7:0]                 hiAddrOeN,
   output logic                       pinOverride,
   output logic                       aleOut,
   output logic                       wrN,
   output logic                       rdN,
   output logic                       keeperEn,
   output logic [7:0]                 keeperLevel
);

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [7:0] mcuCtrl_q;
   logic [7:0] xmemA_q;
   logic [7:0] xmemB_q;
   logic [7:0] regRdata_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         mcuCtrl_q <= xmem_pkg::MCU_CTRL_RST;
         xmemA_q   <= xmem_pkg::XMEM_A_RST;
         xmemB_q   <= xmem_pkg::XMEM_B_RST;
      end else if (regWrite) begin
         if (regAddr == xmem_pkg::MCU_CTRL_OFS) begin
            mcuCtrl_q <= regWdata & xmem_pkg::MCU_CTRL_WMASK;
         end else if (regAddr == xmem_pkg::XMEM_A_OFS) begin
            xmemA_q <= regWdata & xmem_pkg::XMEM_A_WMASK;
         end else if (regAddr == xmem_pkg::XMEM_B_OFS) begin
            xmemB_q <= regWdata & xmem_pkg::XMEM_B_WMASK;
         end
      end
   end

   // unmapped reads and idle cycles return zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         regRdata_q <= 8'h00;
      end else if (!regRead) begin
         regRdata_q <= 8'h00;
      end else if (regAddr == xmem_pkg::MCU_CTRL_OFS) begin
         regRdata_q <= mcuCtrl_q;
      end else if (regAddr == xmem_pkg::XMEM_A_OFS) begin
         regRdata_q <= xmemA_q;
      end else if (regAddr == xmem_pkg::XMEM_B_OFS) begin
         regRdata_q <= xmemB_q;
      end else begin
         regRdata_q <= 8'h00;
      end
   end

   assign regRdata = regRdata_q;

   // -----------------------------------------------------------------
   // configuration decode
   // -----------------------------------------------------------------
   xmem_pkg::sector_cfg_type cfg;
   logic                     extEn;
   logic [2:0]               hiMask;
   logic [7:0]               released;
   logic [1:0]               secWait;

   assign extEn      = mcuCtrl_q[xmem_pkg::EXT_EN_BIT];
   assign hiMask     = xmemB_q[xmem_pkg::HI_MASK_LSB +: 3];
   assign cfg.limit  = xmemA_q[xmem_pkg::SEC_LIMIT_LSB +: 3];
   assign cfg.upWait = {xmemA_q[xmem_pkg::UP_WAIT_HI],
                        mcuCtrl_q[xmem_pkg::UP_WAIT_LO]};
   assign cfg.loWait = xmemA_q[xmem_pkg::LO_WAIT_LSB +: 2];

   sector_select u_sector (
      .addr     (accIn.addr),
      .cfg      (cfg),
      .waitCode (secWait)
   );

   high_addr_mask u_mask (
      .code     (hiMask),
      .released (released)
   );

   // -----------------------------------------------------------------
   // bus cycle sequencer
   // -----------------------------------------------------------------
   xmem_pkg::acc_state_type state_q;
   logic                    write_q;
   logic [1:0]              waitSel_q;
   logic [1:0]              waitCnt_q;
   logic                    busy_q;
   logic                    done_q;
   logic [7:0]              accRdata_q;
   logic [7:0]              adOut_q;
   logic                    adOeN_q;
   logic [7:0]              hiAddr_q;
   logic                    ale_q;
   logic                    wrN_q;
   logic                    rdN_q;

   // requests are only taken in idle with the interface enabled
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q    <= xmem_pkg::ST_IDLE;
         write_q    <= 1'b0;
         waitSel_q  <= 2'h0;
         waitCnt_q  <= 2'h0;
         busy_q     <= 1'b0;
         done_q     <= 1'b0;
         accRdata_q <= 8'h00;
         adOut_q    <= 8'h00;
         adOeN_q    <= 1'b1;
         hiAddr_q   <= 8'h00;
         ale_q      <= 1'b0;
         wrN_q      <= 1'b1;
         rdN_q      <= 1'b1;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            xmem_pkg::ST_IDLE: begin
               if (accReq && extEn) begin
                  state_q   <= xmem_pkg::ST_ADDR;
                  write_q   <= accIn.write;
                  waitSel_q <= secWait;
                  busy_q    <= 1'b1;
                  ale_q     <= 1'b1;
                  adOut_q   <= accIn.addr[7:0];
                  adOeN_q   <= 1'b0;
                  hiAddr_q  <= accIn.addr[15:8];
               end
            end
            xmem_pkg::ST_ADDR: begin
               state_q   <= xmem_pkg::ST_STROBE;
               ale_q     <= 1'b0;
               waitCnt_q <= xmem_pkg::strobeWaits(waitSel_q);
               if (write_q) begin
                  wrN_q   <= 1'b0;
                  adOut_q <= accIn.wdata;
               end else begin
                  rdN_q   <= 1'b0;
                  adOeN_q <= 1'b1;
               end
            end
            xmem_pkg::ST_STROBE: begin
               if (waitCnt_q != 2'h0) begin
                  waitCnt_q <= waitCnt_q - 2'h1;
               end else begin
                  wrN_q   <= 1'b1;
                  rdN_q   <= 1'b1;
                  adOeN_q <= 1'b1;
                  done_q  <= 1'b1;
                  if (!write_q) begin
                     accRdata_q <= adIn;
                  end
                  // extra idle cycle before the next address goes out
                  if (waitSel_q == xmem_pkg::WAIT_GAP) begin
                     state_q <= xmem_pkg::ST_GAP;
                  end else begin
                     state_q <= xmem_pkg::ST_IDLE;
                     busy_q  <= 1'b0;
                  end
               end
            end
            xmem_pkg::ST_GAP: begin
               state_q <= xmem_pkg::ST_IDLE;
               busy_q  <= 1'b0;
            end
            default: begin
               state_q <= xmem_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // pin ownership and bus keeper
   // -----------------------------------------------------------------
   logic [7:0] hiOeN_q;
   logic       override_q;
   logic       keeperEn_q;
   logic [7:0] keeperLevel_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         hiOeN_q    <= xmem_pkg::PINS_OFF;
         override_q <= 1'b0;
      end else begin
         override_q <= extEn;
         // released pins go back to the port, so shadowed space is reachable
         hiOeN_q <= extEn ? released : xmem_pkg::PINS_OFF;
      end
   end

   // keeper ignores the interface enable on purpose
   always_ff @(posedge mclk) begin
      if (srst) begin
         keeperEn_q    <= 1'b0;
         keeperLevel_q <= 8'h00;
      end else begin
         keeperEn_q    <= xmemB_q[xmem_pkg::KEEPER_BIT];
         keeperLevel_q <= adOeN_q ? adIn : adOut_q;
      end
   end

   assign accBusy     = busy_q;
   assign accDone     = done_q;
   assign accRdata    = accRdata_q;
   assign adOut       = adOut_q;
   assign adOeN       = adOeN_q;
   assign hiAddrOut   = hiAddr_q;
   assign hiAddrOeN   = hiOeN_q;
   assign pinOverride = override_q;
   assign aleOut      = ale_q;
   assign wrN         = wrN_q;
   assign rdN         = rdN_q;
   assign keeperEn    = keeperEn_q;
   assign keeperLevel = keeperLevel_q;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   logic [2:0] strobeLen_q;
   logic       strobeLow;
   assign strobeLow = !wrN_q || !rdN_q;

   always_ff @(posedge mclk) begin
      if (srst || !strobeLow) begin
         strobeLen_q <= 3'h0;
      end else begin
         strobeLen_q <= strobeLen_q + 3'h1;
      end
   end

   strobe_length_a: assert property (
      $rose(wrN_q || rdN_q) && (wrN_q && rdN_q) |->
         strobeLen_q == {1'b0, xmem_pkg::strobeWaits(waitSel_q)} + 3'h1)
      else $error("strobe length does not match wait select");

   gap_before_addr_a: assert property (
      done_q && waitSel_q == xmem_pkg::WAIT_GAP |-> !ale_q [*2])
      else $error("address driven too early after gap access");

   single_sector_a: assert property (
      cfg.limit == 3'h0 |-> secWait == cfg.upWait)
      else $error("single sector did not use upper wait select");

   sector_pick_a: assert property (
      cfg.limit != 3'h0 |->
         secWait == ((accIn.addr[15:13] >= cfg.limit) ? cfg.upWait : cfg.loWait))
      else $error("wrong sector wait select");

   reserved_a_a: assert property (
      regRead && regAddr == xmem_pkg::XMEM_A_OFS |=> regRdata_q[0] == 1'b0)
      else $error("control A bit 0 read nonzero");

   reserved_b_a: assert property (
      regRead && regAddr == xmem_pkg::XMEM_B_OFS |=> regRdata_q[6:4] == 3'h0)
      else $error("control B bits 6:4 read nonzero");

   keeper_no_enable_a: assert property (
      !extEn && xmemB_q[xmem_pkg::KEEPER_BIT] [*2] |-> keeperEn_q)
      else $error("keeper off while its enable is set");

   full_high_addr_a: assert property (
      extEn && hiMask == 3'h0 |=> hiOeN_q == 8'h00)
      else $error("high address pins not all driven");

   mask_release_a: assert property (
      extEn && hiMask == 3'h3 |=> hiOeN_q == 8'hE0)
      else $error("wrong high pins released");

   port_restore_a: assert property (
      !extEn && state_q == xmem_pkg::ST_IDLE [*2] |->
         !override_q && hiOeN_q == xmem_pkg::PINS_OFF && wrN_q && rdN_q)
      else $error("pins not returned to port");

   // reset itself is the trigger here, so the default disable must not apply
   reset_clear_a: assert property (
      @(posedge mclk) disable iff (1'b0)
      srst |=> mcuCtrl_q == 8'h00 && xmemA_q == 8'h00 && xmemB_q == 8'h00)
      else $error("control bits not cleared by reset");

   read_waits_c:  cover property ($fell(rdN_q) ##1 !rdN_q [*2] ##1 rdN_q);
   write_gap_c:   cover property (done_q && write_q && waitSel_q == xmem_pkg::WAIT_GAP);
   back_to_back_c: cover property (done_q ##[1:2] $rose(ale_q));

endmodule

// file: verification/sram_model.sv
// external sram model hanging on the multiplexed address/data bus
`timescale 1ns/1ns
module sram_model (
   input  wire logic       mclk,
   input  wire logic       aleOut,
   input  wire logic       wrN,
   input  wire logic       rdN,
   input  wire logic [7:0] adOut,
   input  wire logic       adOeN,
   input  wire logic [7:0] hiAddrOut,
   input  wire logic [7:0] hiAddrOeN,
   input  wire logic       keeperEn,
   input  wire logic [7:0] keeperLevel,
   output logic [7:0]      busLevel
);
   // -----------------------------------------------------------------
   // storage and address latch
   // -----------------------------------------------------------------
   logic [7:0]  mem [0:65535];
   logic [15:0] addrQ;
   logic [7:0]  lastQ;

   initial begin
      addrQ = 16'h0000;
      lastQ = 8'h00;
   end

   // released high pins belong to the port, so they carry no address
   always @(posedge mclk) begin
      if (aleOut) addrQ <= {hiAddrOut & ~hiAddrOeN, adOut};
      if (!wrN) mem[addrQ] <= adOut;
      lastQ <= busLevel;
   end

   // -----------------------------------------------------------------
   // wire resolution
   // -----------------------------------------------------------------
   // no pull on the bus: a floating line toggles, so stale values pass only through the keeper when keeperEn is set
   always_comb begin
      if (!adOeN) busLevel = adOut;
      else if (!rdN) busLevel = mem[addrQ];
      else if (keeperEn) busLevel = keeperLevel;
      else busLevel = ~lastQ;
   end
endmodule

// file: verification/tb_top.sv
// self-checking bench for the external memory configuration block
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic                  mclk, srst, regWrite, regRead, accReq;
   logic [7:0]            regAddr, regWdata, adIn, regRdata, accRdata, adOut, v;
   logic [7:0]            hiAddrOut, hiAddrOeN, keeperLevel, d;
   logic                  accBusy, accDone, adOeN, pinOverride, aleOut, wrN, rdN, keeperEn;
   logic [15:0]           a;
   logic [2:0]            lim;
   logic [1:0]            c;
   logic [7:0]            shadow [0:65535];
   xmem_pkg::acc_req_type accIn;
   int                    err_total, compares, seed, i, busySeen;

   xmem_waitstate_config dut_u (.mclk(mclk), .srst(srst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .accReq(accReq), .accIn(accIn), .accBusy(accBusy), .accDone(accDone),
      .accRdata(accRdata), .adIn(adIn), .adOut(adOut), .adOeN(adOeN),
      .hiAddrOut(hiAddrOut), .hiAddrOeN(hiAddrOeN), .pinOverride(pinOverride),
      .aleOut(aleOut), .wrN(wrN), .rdN(rdN), .keeperEn(keeperEn), .keeperLevel(keeperLevel));
   sram_model mem_u (.mclk(mclk), .aleOut(aleOut), .wrN(wrN), .rdN(rdN), .adOut(adOut),
      .adOeN(adOeN), .hiAddrOut(hiAddrOut), .hiAddrOeN(hiAddrOeN), .keeperEn(keeperEn),
      .keeperLevel(keeperLevel), .busLevel(adIn));

   // -----------------------------------------------------------------
   // expectations and bus tasks
   // -----------------------------------------------------------------
   function automatic logic [1:0] pick(input logic [15:0] ad, input logic [2:0] l,
                                       input logic [1:0] up, input logic [1:0] lo);
      if (l == 3'h0 || ad >= {l, 13'h0000}) return up;
      return lo;
   endfunction

   function automatic int waits(input logic [1:0] code);
      return (code == 2'h0) ? 0 : ((code == 2'h1) ? 1 : 2);
   endfunction

   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge mclk);
      regAddr <= ad;
      regWdata <= dt;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
      @(posedge mclk);
      regAddr <= ad;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      @(negedge mclk);
      dt = regRdata;
   endtask

   task automatic cfg(input logic en, input logic [1:0] up, input logic [2:0] l,
                      input logic [1:0] lo, input logic kp, input logic [2:0] m);
      wr(8'h00, {en, up[0], 6'h00});
      wr(8'h01, {1'b0, l, lo, up[1], 1'b0});
      wr(8'h02, {kp, 4'h0, m});
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic acc(input logic [15:0] ad, input logic w, input logic [7:0] dt,
                      input logic [1:0] code);
      int n, nAle, low;
      n = 0;
      nAle = 0;
      low = 0;
      @(posedge mclk);
      accIn <= '{addr: ad, write: w, wdata: dt};
      accReq <= 1'b1;
      @(posedge mclk);
      accReq <= 1'b0;
      while (accDone !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
         if (aleOut === 1'b1) nAle = n;
         if (aleOut === 1'b1) `CHK(hiAddrOut, ad[15:8])
         if (aleOut === 1'b1) `CHK(adOut, ad[7:0])
         if (wrN === 1'b0 || rdN === 1'b0) begin
            low++;
            `CHK(adOeN, !w)
         end
      end
      `CHK(accDone, 1'b1)
      `CHK(low, 1 + waits(code))
      `CHK(n - nAle, 2 + waits(code))
      `CHK(accBusy, code == 2'h3)
      if (!w) `CHK(accRdata, shadow[ad])
      if (w) shadow[ad] = dt;
      n = 0;
      while (accBusy !== 1'b0 && n < 5) begin
         @(negedge mclk);
         n++;
      end
      `CHK(accBusy, 1'b0)
   endtask

   task automatic wrap_up;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // clock, watchdog and scenarios
   // -----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial begin
      #(50 * 20000);
      err_total++;
      wrap_up();
   end

   initial begin
      {regWrite, regRead, accReq, regAddr, regWdata} = '0;
      accIn = '0;
      err_total = 0;
      compares = 0;
      busySeen = 0;
      seed = 6588;
      srst = 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      `CHK({hiAddrOeN, pinOverride, keeperEn}, 10'h3FC)
      for (i = 0; i < 4; i++) begin
         rd(i[7:0], v);
         `CHK(v, 8'h00)
         wr(i[7:0], 8'hFF);
         rd(i[7:0], v);
         `CHK(v, (i == 0) ? 8'hC0 : (i == 1) ? 8'h7E : (i == 2) ? 8'h87 : 8'h00)
      end
      cfg(1'b0, 2'h0, 3'h0, 2'h0, 1'b0, 3'h0);
      // requests while the interface is off must be dropped
      @(posedge mclk);
      accReq <= 1'b1;
      repeat (6) @(negedge mclk) if (accBusy !== 1'b0) busySeen++;
      @(posedge mclk);
      accReq <= 1'b0;
      `CHK(busySeen, 0)
      for (i = 0; i < 8; i++) begin
         cfg(1'b1, 2'h0, 3'h0, 2'h0, 1'b0, i[2:0]);
         `CHK(hiAddrOeN, (i == 7) ? 8'hFF : ~(8'hFF >> i))
         `CHK(pinOverride, 1'b1)
      end
      cfg(1'b0, 2'h0, 3'h0, 2'h0, 1'b1, 3'h0);
      `CHK({hiAddrOeN, pinOverride, keeperEn}, 10'h3FD)
      cfg(1'b0, 2'h0, 3'h0, 2'h0, 1'b0, 3'h0);
      `CHK(keeperEn, 1'b0)
      for (i = 0; i < 48; i++) begin
         lim = 3'($random(seed));
         a = 16'h1100 | 16'($random(seed));
         if (i % 3 == 1 && lim != 3'h0) a = {lim, 13'h0000};
         if (i % 3 == 2 && lim != 3'h0) a = {lim, 13'h0000} - 16'h0001;
         d = 8'($random(seed));
         cfg(1'b1, i[1:0], lim, i[3:2], i[0], 3'h0);
         c = pick(a, lim, i[1:0], i[3:2]);
         acc(a, 1'b1, d, c);
         if (i[0]) `CHK(adIn, d)
         acc(a, 1'b0, 8'h00, c);
      end
      // reset in mid-run must clear everything again
      @(posedge mclk);
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      `CHK({hiAddrOeN, pinOverride, keeperEn}, 10'h3FC)
      rd(8'h01, v);
      `CHK(v, 8'h00)
      wrap_up();
   end
endmodule
